// ==== logic/c2r_pkg.sv ====
// Shared constants for the channel-two indirect register access port.
// Assumes one system clock; the package holds layouts, direction encodings, reset values and the idle word only.
package c2r_pkg;
    // Control and status byte layout
    localparam int unsigned C2R_BYTE_W = 8;
    localparam int unsigned C2R_MODE_BIT = 7;
    localparam int unsigned C2R_DIR_BIT = 6;
    localparam int unsigned C2R_IDX_MSB = 5;
    localparam int unsigned C2R_IDX_W = 6;
    // Process image words and internal register space
    localparam int unsigned C2R_WORD_W = 16;
    localparam int unsigned C2R_REG_COUNT = 64;
    // Direction encoding of the access bit
    localparam logic C2R_DIR_READ = 1'b0;
    localparam logic C2R_DIR_WRITE = 1'b1;
    // Reset values
    localparam logic [7:0] C2R_STATUS_RST = 8'h00;
    localparam logic [15:0] C2R_WORD_RST = 16'h0000;
    // Word shown on the unused high input word during indirect access
    localparam logic [15:0] C2R_IDLE_WORD = 16'h0000;
endpackage : c2r_pkg

// ==== logic/c2r_bank_if.sv ====
// Carrier between the access port and its internal register space.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface c2r_bank_if;
    import c2r_pkg::*;
    logic [C2R_IDX_W-1:0] index;     // Register selected by the access
    logic wr_en;                     // One-cycle write strobe
    logic [C2R_WORD_W-1:0] wr_data;  // Value to store
    logic [C2R_WORD_W-1:0] rd_data;  // Contents of the selected register
    modport port (output index, output wr_en, output wr_data, input rd_data);
    modport bank (input index, input wr_en, input wr_data, output rd_data);
endinterface : c2r_bank_if

// ==== logic/c2r_reg_bank.sv ====
// Internal register space of channel two, reached only through the access port.
// Assumes writes arrive as single-cycle strobes on clk_sys.
`timescale 1ns/1ps
module c2r_reg_bank
    import c2r_pkg::*;
#(
    parameter int unsigned DEPTH = C2R_REG_COUNT,
    parameter int unsigned WIDTH = C2R_WORD_W
) (
    input wire logic clk_sys,  // System clock
    input wire logic reset_n,  // Asynchronous reset, active low
    c2r_bank_if.bank bus       // Index, write strobe and data
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    // Storage cleared at reset so a first read never returns unknowns
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (bus.wr_en) begin
            mem_q[bus.index] <= bus.wr_data;
        end
    end

    // Read path is combinational; the port registers it into the image
    assign bus.rd_data = mem_q[bus.index];
endmodule // c2r_reg_bank

// ==== logic/c2r_access_port.sv ====
// Channel-two control/status handshake with indirect access to the register space.
// Assumes image_exchange is a one-cycle pulse from process-image logic on clk_sys.
//
// Contract
// - Commands for channel two come from the control byte in the output image.
// - Status byte is returned in the input image on every exchange.
// - Control bit 7 high selects register access; byte becomes an access request.
// - Control bits 5..0 carry the six-bit index of the target register.
// - Bit 6 low reads: indexed register appears in the low input word.
// - On a write, the low output word is stored into the indexed register.
// - High input and output words carry nothing during register access.
// - Status bit 7 acknowledges, bit 6 echoes direction, bits 5..0 echo index.
// - Control bit 7 low returns the channel to process data mode.
// - In process data mode status bit 7 reads zero.
`timescale 1ns/1ps
module c2r_access_port
    import c2r_pkg::*;
(
    input wire logic clk_sys,                               // System clock, 40 MHz
    input wire logic reset_n,                               // Asynchronous reset, active low
    input wire logic image_exchange,                        // One-cycle pulse per image exchange
    input wire logic [C2R_BYTE_W-1:0] channel2_control_byte, // Control byte from output image
    input wire logic [C2R_WORD_W-1:0] ch2_output_word_low,  // Low output word from output image
    input wire logic [C2R_WORD_W-1:0] ch2_output_word_high, // High output word from output image
    input wire logic [C2R_WORD_W-1:0] pd_input_low,         // Channel process value, low word
    input wire logic [C2R_WORD_W-1:0] pd_input_high,        // Channel process value, high word
    output logic [C2R_BYTE_W-1:0] channel2_status_byte,     // Status byte to input image
    output logic [C2R_WORD_W-1:0] ch2_input_word_low,       // Low input word to input image
    output logic [C2R_WORD_W-1:0] ch2_input_word_high,      // High input word to input image
    output logic [C2R_WORD_W-1:0] pd_output_low,            // Process output, low word
    output logic [C2R_WORD_W-1:0] pd_output_high,           // Process output, high word
    output logic pd_output_strobe,                          // Pulse when process outputs update
    output logic indirect_mode_ack                          // Level: register access acknowledged
);
    c2r_bank_if bank_bus ();

    logic [C2R_BYTE_W-1:0] status_q;
    logic [C2R_BYTE_W-1:0] status_d;
    logic [C2R_WORD_W-1:0] in_low_q;
    logic [C2R_WORD_W-1:0] in_low_d;
    logic [C2R_WORD_W-1:0] in_high_q;
    logic [C2R_WORD_W-1:0] in_high_d;
    logic [C2R_WORD_W-1:0] pd_low_q;
    logic [C2R_WORD_W-1:0] pd_high_q;
    logic pd_strobe_q;

    // Decode of the control byte
    wire indirect_mode_request = channel2_control_byte[C2R_MODE_BIT];
    wire access_dir = channel2_control_byte[C2R_DIR_BIT];
    wire [C2R_IDX_W-1:0] access_index = channel2_control_byte[C2R_IDX_MSB:0];
    wire reg_request = image_exchange && indirect_mode_request;
    wire write_request = reg_request && (access_dir == C2R_DIR_WRITE);
    wire pd_request = image_exchange && !indirect_mode_request;

    // Register space access; write lands on the same edge the status is updated
    assign bank_bus.index = access_index;
    assign bank_bus.wr_en = write_request;
    assign bank_bus.wr_data = ch2_output_word_low;

    c2r_reg_bank #(
        .DEPTH(C2R_REG_COUNT),
        .WIDTH(C2R_WORD_W)
    ) u_bank (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .bus(bank_bus.bank)
    );

    // Status: acknowledge, echoed direction and index; all zero in process mode
    assign status_d = indirect_mode_request ? {1'b1, access_dir, access_index}
                                            : C2R_STATUS_RST;

    // Low input word: process value, read data, or the last stored word echoed back after a write
    assign in_low_d = !indirect_mode_request ? pd_input_low
                    : (access_dir == C2R_DIR_READ) ? bank_bus.rd_data
                    : ch2_output_word_low;

    // High input word is idle while indirect access is selected
    assign in_high_d = indirect_mode_request ? C2R_IDLE_WORD : pd_input_high;

    // Input image registers, refreshed only on an exchange
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= C2R_STATUS_RST;
            in_low_q <= C2R_WORD_RST;
            in_high_q <= C2R_WORD_RST;
        end else if (image_exchange) begin
            status_q <= status_d;
            in_low_q <= in_low_d;
            in_high_q <= in_high_d;
        end
    end

    // Process outputs freeze during indirect access; the output words then belong to the port
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pd_low_q <= C2R_WORD_RST;
            pd_high_q <= C2R_WORD_RST;
            pd_strobe_q <= 1'b0;
        end else begin
            pd_strobe_q <= pd_request;
            if (pd_request) begin
                pd_low_q <= ch2_output_word_low;
                pd_high_q <= ch2_output_word_high;
            end
        end
    end

    // Image and process outputs straight from flip-flops
    assign channel2_status_byte = status_q;
    assign ch2_input_word_low = in_low_q;
    assign ch2_input_word_high = in_high_q;
    assign pd_output_low = pd_low_q;
    assign pd_output_high = pd_high_q;
    assign pd_output_strobe = pd_strobe_q;
    assign indirect_mode_ack = status_q[C2R_MODE_BIT];

    // Checks on the handshake, one clock domain only
    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    sequence s_reg_req;
        image_exchange && channel2_control_byte[C2R_MODE_BIT];
    endsequence

    sequence s_read_req;
        s_reg_req ##0 (channel2_control_byte[C2R_DIR_BIT] == C2R_DIR_READ);
    endsequence

    sequence s_write_req;
        s_reg_req ##0 (channel2_control_byte[C2R_DIR_BIT] == C2R_DIR_WRITE);
    endsequence

    sequence s_pd_req;
        image_exchange && !channel2_control_byte[C2R_MODE_BIT];
    endsequence

    // Request acknowledged on the next cycle and still held one cycle later when no exchange follows at once
    ack_raised_a: assert property (s_reg_req ##1 !image_exchange |-> indirect_mode_ack ##1 indirect_mode_ack)
        else $error("register access not acknowledged");

    // Status echoes the accessed index
    index_echo_a: assert property (s_reg_req |=> channel2_status_byte[5:0] == $past(channel2_control_byte[5:0]))
        else $error("status index does not echo control index");

    // Status echoes the access direction
    dir_echo_a: assert property (s_reg_req |=> channel2_status_byte[6] == $past(channel2_control_byte[6]))
        else $error("status direction does not echo control direction");

    // Read data is the stored value before any same-cycle write
    read_data_a: assert property (s_read_req |=> ch2_input_word_low == $past(bank_bus.rd_data))
        else $error("read data not presented in low input word");

    // Write strobe, data and index reach the register space together
    write_store_a: assert property (s_write_req |-> bank_bus.wr_en && bank_bus.wr_data == ch2_output_word_low
                                    && bank_bus.index == channel2_control_byte[5:0])
        else $error("write not passed to register space");

    // No stray writes outside an access request
    write_only_req_a: assert property (bank_bus.wr_en |-> image_exchange && channel2_control_byte[7])
        else $error("register written without an access request");

    // High words stay out of register traffic
    high_idle_a: assert property (s_reg_req |=> ch2_input_word_high == C2R_IDLE_WORD && !pd_output_strobe
                                  && $stable(pd_output_high))
        else $error("high words used during register access");

    // Process mode restores the status and the low input value
    pd_mode_a: assert property (s_pd_req |=> channel2_status_byte == C2R_STATUS_RST
                                && ch2_input_word_low == $past(pd_input_low) && pd_output_strobe)
        else $error("process data mode not restored");

    // Status only moves on an exchange
    status_hold_a: assert property (!image_exchange |=> $stable(channel2_status_byte))
        else $error("status changed between exchanges");

    // Leaving register access drops the acknowledge
    mode_exit_a: assert property (indirect_mode_ack ##0 s_pd_req |=> !indirect_mode_ack)
        else $error("clearing mode bit did not end register access");

    // Reads report direction zero in the status byte
    read_dir_a: assert property (s_read_req |=> !channel2_status_byte[C2R_DIR_BIT])
        else $error("read not reported as read in status");

    // Writes report acknowledge and write direction
    write_dir_a: assert property (s_write_req |=> channel2_status_byte[C2R_MODE_BIT]
                                  && channel2_status_byte[C2R_DIR_BIT])
        else $error("write not reported in status");

    // Low input word echoes the word just stored
    write_echo_a: assert property (s_write_req |=> ch2_input_word_low == $past(ch2_output_word_low))
        else $error("written word not echoed in low input word");

    // A read never disturbs the register space
    read_no_wr_a: assert property (s_read_req |-> !bank_bus.wr_en)
        else $error("register space written during a read");

    // Input words move only on an exchange
    words_hold_a: assert property (!image_exchange |=> $stable(ch2_input_word_low)
                                   && $stable(ch2_input_word_high))
        else $error("input words changed between exchanges");

    // Process outputs move only on a process-mode exchange
    pd_hold_a: assert property (!pd_request |=> $stable(pd_output_low) && $stable(pd_output_high))
        else $error("process outputs changed outside process mode");

    // Strobe only ever follows a process-mode exchange
    strobe_cause_a: assert property (pd_output_strobe |-> $past(pd_request))
        else $error("process strobe without a process exchange");

    // Process mode takes both output words
    pd_copy_a: assert property (s_pd_req |=> pd_output_low == $past(ch2_output_word_low)
                                && pd_output_high == $past(ch2_output_word_high))
        else $error("process output words not taken");

    // Process mode passes the high input value through
    pd_high_in_a: assert property (s_pd_req |=> ch2_input_word_high == $past(pd_input_high))
        else $error("process high input word not passed");
endmodule // c2r_access_port

// ==== verif/c2r_ctrl_model.sv ====
// Controller model that drives the channel-two output image and the exchange pulse.
// Assumes the access port answers one clk_sys cycle after the exchange edge.
`timescale 1ns/1ps
module c2r_ctrl_model
    import c2r_pkg::*;
(
    input wire logic clk_sys,                       // System clock
    output logic image_exchange,                    // One-cycle exchange pulse
    output logic [C2R_BYTE_W-1:0] channel2_control_byte, // Control byte
    output logic [C2R_WORD_W-1:0] ch2_output_word_low,   // Low output word
    output logic [C2R_WORD_W-1:0] ch2_output_word_high,  // High output word
    output logic [C2R_WORD_W-1:0] pd_input_low,     // Channel process value, low
    output logic [C2R_WORD_W-1:0] pd_input_high     // Channel process value, high
);
    // Quiet image at time zero
    initial begin
        image_exchange = 1'b0;
        channel2_control_byte = 8'h00;
        ch2_output_word_low = 16'h0000;
        ch2_output_word_high = 16'h0000;
        pd_input_low = 16'h0000;
        pd_input_high = 16'h0000;
    end

    // One exchange; output image lines are scrambled afterwards so stale values never look valid
    task automatic exchange(input logic [7:0] cb, input logic [15:0] lo, input logic [15:0] hi,
                            input logic [15:0] pd_lo, input logic [15:0] pd_hi);
        @(posedge clk_sys);
        image_exchange <= 1'b1;
        channel2_control_byte <= cb;
        ch2_output_word_low <= lo;
        ch2_output_word_high <= hi;
        pd_input_low <= pd_lo;
        pd_input_high <= pd_hi;
        @(posedge clk_sys);
        image_exchange <= 1'b0;
        channel2_control_byte <= ~cb;
        ch2_output_word_low <= ~lo;
        ch2_output_word_high <= ~hi;
        #1;
    endtask
endmodule // c2r_ctrl_model

// ==== verif/testbench.sv ====
// Self-checking bench for the channel-two access port, driven through the controller model.
// Assumes the design answers one cycle after each exchange.
`timescale 1ns/1ps
module testbench
    import c2r_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    int mismatches = 0;
    int n_tests = 0;
    wire logic ex;
    wire logic [7:0] cb, st;
    wire logic [15:0] olo, ohi, pdi_lo, pdi_hi, ilo, ihi, pdo_lo, pdo_hi;
    wire logic strobe, ack;

    // 40 MHz clock
    always #12.5 clk_sys = ~clk_sys;

    c2r_ctrl_model i_ctrl (.clk_sys(clk_sys), .image_exchange(ex), .channel2_control_byte(cb),
        .ch2_output_word_low(olo), .ch2_output_word_high(ohi), .pd_input_low(pdi_lo), .pd_input_high(pdi_hi));
    c2r_access_port i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .image_exchange(ex),
        .channel2_control_byte(cb), .ch2_output_word_low(olo), .ch2_output_word_high(ohi),
        .pd_input_low(pdi_lo), .pd_input_high(pdi_hi), .channel2_status_byte(st),
        .ch2_input_word_low(ilo), .ch2_input_word_high(ihi), .pd_output_low(pdo_lo),
        .pd_output_high(pdo_hi), .pd_output_strobe(strobe), .indirect_mode_ack(ack));

    // Four-state compare of one result word
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Register write; the high words carry junk that must not show up
    task automatic reg_wr(input logic [5:0] idx, input logic [15:0] val);
        i_ctrl.exchange({1'b1, C2R_DIR_WRITE, idx}, val, 16'hA5A5, 16'h1111, 16'h2222);
        chk({8'h00, st}, {8'h00, 1'b1, C2R_DIR_WRITE, idx}, "write status");
        chk({15'h0000, ack}, 16'h0001, "write ack");
        chk(ilo, val, "write echo");
        chk(ihi, C2R_IDLE_WORD, "high word in access");
    endtask

    // Register read; status, data and idle high word are each checked after the exchange
    task automatic reg_rd(input logic [5:0] idx, input logic [15:0] exp);
        i_ctrl.exchange({1'b1, C2R_DIR_READ, idx}, 16'h5A5A, 16'h3C3C, 16'h4444, 16'h5555);
        chk({8'h00, st}, {8'h00, 1'b1, C2R_DIR_READ, idx}, "read status");
        chk(ilo, exp, "read data");
        chk(ihi, C2R_IDLE_WORD, "high word in read");
    endtask

    // Verdict and end of run
    task automatic report_and_stop();
        $display("Counts: %0d comparisons, %0d mismatches", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog at 2000 cycles, well beyond the 45 or so cycles the tests need
    initial begin
        #50000;
        mismatches++;
        $display("Error at %0t: watchdog expired", $time);
        report_and_stop();
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk({8'h00, st}, {8'h00, C2R_STATUS_RST}, "reset status");
        chk(ilo | ihi | pdo_lo | pdo_hi, C2R_WORD_RST, "reset words");
        chk({14'h0000, strobe, ack}, 16'h0000, "reset flags");
        $display("Test reset done");
        reg_wr(6'd0, 16'hC0DE);
        reg_wr(6'd63, 16'hBEEF);
        reg_wr(6'd5, 16'h1234);
        reg_rd(6'd63, 16'hBEEF);
        reg_rd(6'd0, 16'hC0DE);
        reg_rd(6'd5, 16'h1234);
        reg_rd(6'd7, 16'h0000);
        $display("Test register access done");
        i_ctrl.exchange(8'h7F, 16'hAAAA, 16'hBBBB, 16'hCCCC, 16'hDDDD);
        chk({8'h00, st}, 16'h0000, "process status");
        chk({15'h0000, ack}, 16'h0000, "process ack");
        chk(ilo, 16'hCCCC, "process in low");
        chk(ihi, 16'hDDDD, "process in high");
        chk(pdo_lo, 16'hAAAA, "process out low");
        chk(pdo_hi, 16'hBBBB, "process out high");
        chk({15'h0000, strobe}, 16'h0001, "strobe high");
        @(posedge clk_sys);
        #1;
        chk({15'h0000, strobe}, 16'h0000, "strobe one cycle");
        $display("Test process mode done");
        reg_wr(6'd9, 16'h0F0F);
        chk(pdo_lo, 16'hAAAA, "frozen out low");
        chk(pdo_hi, 16'hBBBB, "frozen out high");
        chk({15'h0000, strobe}, 16'h0000, "no strobe in access");
        repeat (3) @(posedge clk_sys);
        #1;
        chk({8'h00, st}, {8'h00, 1'b1, C2R_DIR_WRITE, 6'd9}, "status holds");
        reg_rd(6'd9, 16'h0F0F);
        $display("Test mode switch done");
        report_and_stop();
    end
endmodule // testbench
